/* design/pifas_pkg.sv */
// shared constants and carrier types for the aliased register state
// Functional notes
// - stack top pointer is zero after each packed-integer instruction
// - a register write fills the aliased exponent with ones
// - all but the empty-state instruction set every tag valid 00
// - the empty-state instruction marks every tag field empty
// - pending float exception gives numeric error 16 and low error out
// - held instruction restarts after the numeric error handler returns
// - packed-integer instructions raise no numeric fault of their own
// - memory operand faults are reported as for any other instruction
// - packed-integer registers and tags share the float register storage
// - a bus-lock prefixed instruction raises invalid opcode
// - emulation control bit makes any such instruction invalid opcode
// - identify instruction reports the feature in feature flag bit 23
// - address and segment prefixes act on memory forms; others reserved
package pifas_pkg;
  localparam int unsigned NREG = 8;
  localparam int unsigned TOP_W = 3;
  localparam int unsigned MANT_W = 64;
  localparam int unsigned EXP_W = 16;
  localparam logic [1:0] TAG_VALID = 2'h0;
  localparam logic [1:0] TAG_EMPTY = 2'h3;
  localparam logic [TOP_W-1:0] TOP_CLEAR = 3'h0;
  localparam logic [EXP_W-1:0] EXP_ONES = 16'hFFFF;
  localparam logic [7:0] VEC_NUMERIC = 8'h10;
  localparam logic [7:0] VEC_INVALID = 8'h06;
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam int unsigned FEAT_BIT = 23;
  localparam logic [31:0] FEAT_RESET = 32'h0000_0000;
  // axi offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FEAT = 8'h08;
  localparam logic [7:0] OFS_TAGS = 8'h0C;
  localparam logic [7:0] OFS_VEC = 8'h10;
  localparam int unsigned CTRL_EMU = 0;
  localparam int unsigned CTRL_PEND = 1;
  localparam int unsigned CTRL_RET = 2;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PIFAS_OP_NORMAL,
    PIFAS_OP_EMPTY,
    PIFAS_OP_IDENTIFY
  } pifas_op_t;

  typedef struct packed {
    logic valid;
    pifas_op_t op;
    logic lock_prefix;
    logic has_mem;
    logic mem_fault;
    logic wr_en;
    logic [TOP_W-1:0] wr_idx;
    logic [MANT_W-1:0] wr_data;
  } pifas_instr_t;

  typedef struct packed {
    logic done;
    logic fault;
    logic [7:0] vector;
    logic mem_fault;
  } pifas_result_t;
endpackage : pifas_pkg

/* design/pifas_stack_store.sv */
// shared float and packed-integer register storage
`timescale 1ns/100ps
`default_nettype none
module pifas_stack_store
  import pifas_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write port
  input wire logic wr_en,
  input wire logic [TOP_W-1:0] wr_idx,
  input wire logic [MANT_W-1:0] wr_data,
  // read port
  input wire logic [TOP_W-1:0] rd_idx,
  output logic [MANT_W+EXP_W-1:0] rd_data
);
  typedef struct packed {
    logic [NREG-1:0][MANT_W+EXP_W-1:0] regs;
  } pifas_store_t;
  pifas_store_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.regs[wr_idx] = {EXP_ONES, wr_data};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.regs[rd_idx];
endmodule : pifas_stack_store
`default_nettype wire

/* design/pifas_top.sv */
// alias state controller with axi4-lite control and status
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pifas_top
  import pifas_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // instruction issue from decode
  input wire pifas_instr_t instr,
  output logic instr_ready,
  output pifas_result_t result,
  // float status and tag state
  output logic [TOP_W-1:0] stack_top_pointer,
  output logic [2*NREG-1:0] tag_word,
  output logic numeric_error_out_n,
  output logic [MANT_W+EXP_W-1:0] reg_rd_data,
  input wire logic [TOP_W-1:0] reg_rd_idx,
  // axi4-lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  typedef struct packed {
    logic [TOP_W-1:0] top;
    logic [2*NREG-1:0] tags;
    logic emu;
    logic pend;
    logic err_n;
    logic held;
    pifas_result_t res;
    logic [7:0] last_vec;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rdy;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic [MANT_W+EXP_W-1:0] rd;
  } pifas_state_t;
  pifas_state_t s_reg, s_next;

  logic st_wr_en;
  logic [MANT_W+EXP_W-1:0] st_rd;

  function automatic logic [31:0] rd_mux(input logic [7:0] a,
      input pifas_state_t s);
    case (a)
      OFS_CTRL: rd_mux = {29'h0, 1'b0, s.pend, s.emu};
      OFS_STATUS: rd_mux = {27'h0, s.held, ~s.err_n, s.top};
      OFS_FEAT: rd_mux = FEAT_RESET | (32'h1 << FEAT_BIT);
      OFS_TAGS: rd_mux = {16'h0, s.tags};
      OFS_VEC: rd_mux = {24'h0, s.last_vec};
      default: rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_FEAT) ||
             (a == OFS_TAGS) || (a == OFS_VEC);
  endfunction : mapped

  logic take;
  logic [31:0] wmask;
  logic [31:0] ctrl_w;
  logic do_write;
  logic hold_set;

  always_comb begin
    s_next = s_reg;
    s_next.res = '0;
    st_wr_en = 1'b0;
    wmask = {{8{s_wstrb[3]}}, {8{s_wstrb[2]}}, {8{s_wstrb[1]}},
             {8{s_wstrb[0]}}};
    ctrl_w = 32'h0;
    do_write = 1'b0;
    hold_set = 1'b0;
    take = instr.valid && s_reg.rdy;
    // instruction handling
    if (take) begin
      s_next.res.done = 1'b1;
      if (instr.op == PIFAS_OP_IDENTIFY) begin
        s_next.res.vector = VEC_NONE;
      end else if (s_reg.emu || instr.lock_prefix) begin
        s_next.res.fault = 1'b1;
        s_next.res.vector = VEC_INVALID;
        s_next.last_vec = VEC_INVALID;
      end else if (s_reg.pend) begin
        // held, not executed; decode retries after handler return
        s_next.res.fault = 1'b1;
        s_next.res.vector = VEC_NUMERIC;
        s_next.last_vec = VEC_NUMERIC;
        s_next.err_n = 1'b0;
        s_next.held = 1'b1;
        hold_set = 1'b1;
      end else if (instr.has_mem && instr.mem_fault) begin
        // prefixes only matter to the address path upstream
        s_next.res.fault = 1'b1;
        s_next.res.mem_fault = 1'b1;
      end else begin
        // no numeric check: only the pending one can fault
        s_next.top = TOP_CLEAR;
        if (instr.op == PIFAS_OP_EMPTY) begin
          s_next.tags = {NREG{TAG_EMPTY}};
        end else begin
          s_next.tags = {NREG{TAG_VALID}};
          st_wr_en = instr.wr_en;
        end
      end
    end
    // axi write channel
    if (s_awready && s_awvalid) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_awaddr;
    end
    if (s_wready && s_wvalid) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_wdata & wmask;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      do_write = 1'b1;
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_reg.awaddr) ? RESP_OK : RESP_SLVERR;
      if (s_reg.awaddr == OFS_CTRL) begin
        ctrl_w = s_reg.wdata;
        s_next.emu = ctrl_w[CTRL_EMU];
        // handler return: clears pending and releases the held one
        if (ctrl_w[CTRL_RET]) begin
          s_next.pend = 1'b0;
          // a hold raised in this same cycle wins over the return
          if (!hold_set) begin
            s_next.err_n = 1'b1;
            s_next.held = 1'b0;
          end
        end else begin
          s_next.pend = ctrl_w[CTRL_PEND] | s_reg.pend;
        end
      end
    end
    if (s_reg.bvalid && s_bready) begin
      s_next.bvalid = 1'b0;
    end
    // axi read channel
    if (s_arready && s_arvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_mux(s_araddr, s_reg);
      s_next.rresp = mapped(s_araddr) ? RESP_OK : RESP_SLVERR;
    end else if (s_reg.rvalid && s_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (!do_write) begin
      ctrl_w = 32'h0;
    end
    // readies kept as flops so every output comes straight from state
    s_next.rdy = !s_next.held;
    s_next.awrdy = !s_next.aw_got;
    s_next.wrdy = !s_next.w_got;
    s_next.arrdy = !s_next.rvalid;
    s_next.rd = st_rd;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.tags <= {NREG{TAG_EMPTY}};
      s_reg.err_n <= 1'b1;
      s_reg.awrdy <= 1'b1;
      s_reg.wrdy <= 1'b1;
      s_reg.arrdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  pifas_stack_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(st_wr_en),
    .wr_idx(instr.wr_idx),
    .wr_data(instr.wr_data),
    .rd_idx(reg_rd_idx),
    .rd_data(st_rd)
  );

  assign instr_ready = s_reg.rdy;
  assign reg_rd_data = s_reg.rd;
  assign result = s_reg.res;
  assign stack_top_pointer = s_reg.top;
  assign tag_word = s_reg.tags;
  assign numeric_error_out_n = s_reg.err_n;
  assign s_awready = s_reg.awrdy;
  assign s_wready = s_reg.wrdy;
  assign s_bvalid = s_reg.bvalid;
  assign s_bresp = s_reg.bresp;
  assign s_arready = s_reg.arrdy;
  assign s_rvalid = s_reg.rvalid;
  assign s_rdata = s_reg.rdata;
  assign s_rresp = s_reg.rresp;
endmodule : pifas_top
`default_nettype wire

/* tb/pifas_checker.sv */
// assertions on the alias state controller ports
`timescale 1ns/100ps
`default_nettype none
module pifas_checker
  import pifas_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // issue and state
  input wire pifas_instr_t instr,
  input wire logic instr_ready,
  input wire pifas_result_t result,
  input wire logic [TOP_W-1:0] stack_top_pointer,
  input wire logic [2*NREG-1:0] tag_word,
  input wire logic numeric_error_out_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic tk = instr.valid && instr_ready;
  property p_top; result.done |-> stack_top_pointer == TOP_CLEAR; endproperty
  a_top: assert property (p_top) else $error("top not clear");
  property p_val;
    tk && instr.op == PIFAS_OP_NORMAL ##1 result.done && !result.fault
      |-> tag_word == 16'h0000;
  endproperty
  a_val: assert property (p_val) else $error("tags not valid");
  property p_emp;
    tk && instr.op == PIFAS_OP_EMPTY ##1 result.done && !result.fault
      |-> tag_word == 16'hFFFF;
  endproperty
  a_emp: assert property (p_emp) else $error("tags not empty");
  property p_err; result.fault && result.vector == VEC_NUMERIC
    |-> !numeric_error_out_n && !instr_ready; endproperty
  a_err: assert property (p_err) else $error("no error out");
  property p_hold; !numeric_error_out_n |-> !instr_ready; endproperty
  a_hold: assert property (p_hold) else $error("taken while held");
  property p_lock; tk && instr.lock_prefix && instr.op != PIFAS_OP_IDENTIFY
    |=> result.fault && result.vector == VEC_INVALID; endproperty
  a_lock: assert property (p_lock) else $error("lock not refused");
  property p_id; tk && instr.op == PIFAS_OP_IDENTIFY
    |=> result.done && !result.fault && result.vector == VEC_NONE; endproperty
  a_id: assert property (p_id) else $error("identify faulted");
  property p_mem; tk && instr.has_mem && instr.mem_fault
    && instr.op != PIFAS_OP_IDENTIFY |=> result.fault; endproperty
  a_mem: assert property (p_mem) else $error("fault lost");
  property p_stall; !instr_ready |=> !result.done; endproperty
  a_stall: assert property (p_stall) else $error("result while held");
endmodule : pifas_checker
`default_nettype wire

/* tb/pifas_decode_model.sv */
// decode-side model that presents instructions to the controller
`timescale 1ns/100ps
`default_nettype none
module pifas_decode_model
  import pifas_pkg::*;
(
  // clock
  input wire logic aclk,
  // issue handshake
  input wire logic instr_ready,
  output var pifas_instr_t instr
);
  initial instr = '0;
  // held until taken, so a stalled one restarts unchanged
  task automatic issue(input pifas_instr_t i, output bit ok);
    int n;
    n = 0;
    @(posedge aclk);
    instr <= i;
    do begin
      @(posedge aclk);
      n++;
    end while (!instr_ready && n < 300);
    ok = instr_ready;
    i = ~i;
    i.valid = 1'b0;
    instr <= i;
  endtask : issue
endmodule : pifas_decode_model
`default_nettype wire

/* tb/pifas_top_tb.sv */
// self-checking bench for the alias state controller
`timescale 1ns/100ps
`default_nettype none
module pifas_top_tb;
  import pifas_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  pifas_instr_t instr;
  pifas_result_t result;
  logic instr_ready, numeric_error_out_n;
  logic [2:0] stack_top_pointer, reg_rd_idx = '0;
  logic [15:0] tag_word, tags = 16'hFFFF;
  logic [79:0] reg_rd_data;
  logic [7:0] s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata, rs = 32'h698D;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [63:0] d;
  bit emu, pend, errl;
  int error_cnt, cmp_count;
  pifas_top dut_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .instr(instr),
    .instr_ready(instr_ready),
    .result(result),
    .stack_top_pointer(stack_top_pointer),
    .tag_word(tag_word),
    .numeric_error_out_n(numeric_error_out_n),
    .reg_rd_data(reg_rd_data),
    .reg_rd_idx(reg_rd_idx),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready)
  );
  pifas_decode_model dec_u (
    .aclk(aclk),
    .instr_ready(instr_ready),
    .instr(instr)
  );
  initial forever #4 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic pifas_instr_t mk(input pifas_op_t o,
      input logic [3:0] f, input logic [2:0] x);
    mk = '0;
    mk.op = o;
    {mk.lock_prefix, mk.has_mem, mk.mem_fault, mk.wr_en} = f;
    mk.wr_idx = x;
    mk.wr_data = d;
  endfunction : mk
  task automatic chk(input logic [79:0] g, input logic [79:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid && n < 99);
    s_bready <= 1'b0;
    chk({s_bvalid, s_bresp}, {1'b1, e});
    if (n >= 99) end_of_test();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid && n < 99);
    s_rready <= 1'b0;
    chk({s_rvalid, s_rresp, s_rdata}, {1'b1, e});
    if (n >= 99) end_of_test();
  endtask : rd
  task automatic run(input pifas_instr_t i);
    bit ok;
    logic ef, em;
    logic [7:0] ev;
    {ef, em, ev} = '0;
    i.valid = 1'b1;
    if (i.op == PIFAS_OP_IDENTIFY) ef = 1'b0;
    else if (emu || i.lock_prefix) {ef, ev} = {1'b1, VEC_INVALID};
    else if (pend) {ef, ev, errl} = {1'b1, VEC_NUMERIC, 1'b1};
    else if (i.has_mem && i.mem_fault) {ef, em} = 2'h3;
    else tags = (i.op == PIFAS_OP_EMPTY) ? 16'hFFFF : 16'h0000;
    dec_u.issue(i, ok);
    if (!ok) begin
      error_cnt++;
      end_of_test();
    end
    @(negedge aclk);
    chk({result.fault, result.vector, result.mem_fault, result.done},
      {ef, ev, em, 1'b1});
    chk({stack_top_pointer, tag_word, numeric_error_out_n},
      {TOP_CLEAR, tags, !errl});
  endtask : run
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({stack_top_pointer, tag_word, numeric_error_out_n},
      {TOP_CLEAR, 16'hFFFF, 1'b1});
    rd(OFS_FEAT, {RESP_OK, 32'h0080_0000});
    rd(OFS_STATUS, {RESP_OK, 32'h0});
    rd(8'h14, {RESP_SLVERR, 32'h0});
    wr(8'h14, 32'h7, RESP_SLVERR);
    for (int k = 0; k < NREG; k++) begin
      rs = lfsr(rs);
      d = {rs, ~rs};
      run(mk(PIFAS_OP_NORMAL, 4'h1, k[2:0]));
      @(posedge aclk) reg_rd_idx <= k[2:0];
      @(posedge aclk);
      @(negedge aclk);
      chk(reg_rd_data, {EXP_ONES, d});
    end
    run(mk(PIFAS_OP_EMPTY, 4'h0, 3'h0));
    rd(OFS_TAGS, {RESP_OK, 32'h0000_FFFF});
    run(mk(PIFAS_OP_NORMAL, 4'h9, 3'h1));
    emu = 1'b1;
    wr(OFS_CTRL, 32'h1, RESP_OK);
    run(mk(PIFAS_OP_NORMAL, 4'h0, 3'h2));
    run(mk(PIFAS_OP_IDENTIFY, 4'h0, 3'h0));
    emu = 1'b0;
    wr(OFS_CTRL, 32'h0, RESP_OK);
    run(mk(PIFAS_OP_NORMAL, 4'h7, 3'h3));
    run(mk(PIFAS_OP_NORMAL, 4'h5, 3'h3));
    pend = 1'b1;
    wr(OFS_CTRL, 32'h2, RESP_OK);
    run(mk(PIFAS_OP_NORMAL, 4'h1, 3'h4));
    rd(OFS_STATUS, {RESP_OK, 32'h18});
    {pend, errl} = 2'h0;
    // offered while held: must wait for the handler return, then run
    fork
      run(mk(PIFAS_OP_NORMAL, 4'h1, 3'h4));
      begin
        repeat (4) @(posedge aclk);
        wr(OFS_CTRL, 32'h4, RESP_OK);
      end
    join
    run(mk(PIFAS_OP_EMPTY, 4'h0, 3'h0));
    end_of_test();
  end
endmodule : pifas_top_tb
bind pifas_top pifas_checker chk_u (.aclk(aclk), .aresetn(aresetn),
  .instr(instr), .instr_ready(instr_ready), .result(result),
  .stack_top_pointer(stack_top_pointer), .tag_word(tag_word),
  .numeric_error_out_n(numeric_error_out_n));
`default_nettype wire
